// file: rtl/fcbd_pkg.sv
// Constants, types and layouts shared by the compare and branch decoder.
package fcbd_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_INSTR = 8'h04;
  localparam logic [7:0] A_OPND  = 8'h08;
  localparam logic [7:0] A_FPSR  = 8'h0c;
  localparam logic [7:0] A_DISP  = 8'h10;
  localparam logic [7:0] A_DEC   = 8'h14;
  localparam logic [7:0] A_BRCH  = 8'h18;

  // ==========================================================================
  // Status word fields and reset values
  localparam int CC_N     = 27;
  localparam int CC_Z     = 26;
  localparam int CC_I     = 25;
  localparam int CC_NAN   = 24;
  localparam int EX_BR_UNORD    = 15;
  localparam int EX_SIG_NAN     = 14;
  localparam int EX_OPND_ERR    = 13;
  localparam int EX_OVER        = 12;
  localparam int EX_UNDER       = 11;
  localparam int EX_DIV_ZERO    = 10;
  localparam int EX_INEXACT     = 9;
  localparam int EX_DEC_INEXACT = 8;
  localparam logic [31:0] RST_FPSR = 32'h0000_0000;
  localparam logic [2:0]  RST_ID   = 3'h1;

  // ==========================================================================
  // Instruction encodings
  localparam logic [3:0] TOP_NIB = 4'hf;
  localparam logic [2:0] CMP_SEL = 3'h0;
  localparam logic [1:0] BR_SEL  = 2'h1;
  localparam logic [6:0] CMP_EXT = 7'h38;
  localparam logic [2:0] FMT_L = 3'h0;
  localparam logic [2:0] FMT_S = 3'h1;
  localparam logic [2:0] FMT_P = 3'h3;
  localparam logic [2:0] FMT_W = 3'h4;
  localparam logic [2:0] FMT_B = 3'h6;
  localparam logic [2:0] FMT_BAD = 3'h7;
  localparam logic [2:0] EA_DREG = 3'h0;
  localparam logic [2:0] EA_AREG = 3'h1;
  localparam logic [2:0] EA_EXT  = 3'h7;
  localparam logic [2:0] EX_ABSW = 3'h0;
  localparam logic [2:0] EX_ABSL = 3'h1;
  localparam logic [2:0] EX_PCD  = 3'h2;
  localparam logic [2:0] EX_PCX  = 3'h3;
  localparam logic [2:0] EX_IMM  = 3'h4;

  // Operand classes supplied by the arithmetic unit.
  localparam logic [1:0] CL_FIN  = 2'h0;
  localparam logic [1:0] CL_ZERO = 2'h1;
  localparam logic [1:0] CL_INF  = 2'h2;
  localparam logic [1:0] CL_NAN  = 2'h3;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } fcbd_st_e;

  typedef struct packed {
    logic       dec_inexact_in;
    logic       diff_z;
    logic       diff_n;
    logic       src_sig_nan;
    logic       src_sign;
    logic [1:0] src_cls;
    logic       dst_sig_nan;
    logic       dst_sign;
    logic [1:0] dst_cls;
  } fcbd_opnd_s;

  typedef struct packed {
    logic       is_cmp;
    logic       is_br;
    logic       id_ok;
    logic       rm;
    logic       ea_ok;
    logic       size;
    logic [2:0] spec;
    logic [2:0] dst;
    logic [5:0] pred;
  } fcbd_dec_s;

  typedef struct packed {
    fcbd_st_e   st;
    logic       pready;
    logic       pslverr;
    logic [31:0] prdata;
    logic [2:0] id;
    logic [31:0] instr;
    fcbd_opnd_s opnd;
    logic [31:0] disp;
    logic [31:0] fpsr;
    fcbd_dec_s  dec;
    logic [31:0] disp_out;
    logic       br_true;
  } fcbd_state_s;

endpackage

// file: rtl/fcbd_cmp_cc.sv
// Condition code table of the floating-point compare.
`timescale 1ns/1ns
`default_nettype none
module fcbd_cmp_cc
  import fcbd_pkg::*;
(
  input  wire fcbd_opnd_s i_opnd,
  output logic            o_n,
  output logic            o_z,
  output logic            o_nan
);
  logic dp;
  logic sp;
  logic [1:0] sc;

  // ==========================================================================
  // table lookup
  always_comb begin
    dp = ~i_opnd.dst_sign;
    sp = ~i_opnd.src_sign;
    sc = i_opnd.src_cls;
    o_n = 1'b0;
    o_z = 1'b0;
    o_nan = (i_opnd.dst_cls == CL_NAN) | (sc == CL_NAN);
    if (!o_nan) begin
      unique case (i_opnd.dst_cls)
        CL_FIN: begin
          if (sc == CL_FIN && dp == sp) begin
            o_n = i_opnd.diff_n;
            o_z = i_opnd.diff_z;
          end else if (sc == CL_INF) begin
            o_n = sp;
          end else begin
            o_n = ~dp;
          end
        end
        CL_ZERO: begin
          o_z = (sc == CL_ZERO);
          o_n = (sc == CL_ZERO) ? ~dp : sp;
        end
        default: begin
          o_z = (sc == CL_INF) && (dp == sp);
          o_n = ~dp;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: rtl/fcbd_cond_eval.sv
// Conditional predicate evaluation against the condition codes.
`timescale 1ns/1ns
`default_nettype none
module fcbd_cond_eval
  import fcbd_pkg::*;
(
  input  wire logic [5:0] i_pred,
  input  wire logic       i_n,
  input  wire logic       i_z,
  input  wire logic       i_nan,
  output logic            o_true,
  output logic            o_unord
);
  logic t;

  // ==========================================================================
  // one of 32 tests
  always_comb begin
    unique case (i_pred[3:0])
      4'h0: t = 1'b0;
      4'h1: t = i_z;
      4'h2: t = ~(i_nan | i_z | i_n);
      4'h3: t = i_z | ~(i_nan | i_n);
      4'h4: t = i_n & ~(i_nan | i_z);
      4'h5: t = i_z | (i_n & ~i_nan);
      4'h6: t = ~(i_nan | i_z);
      4'h7: t = ~i_nan;
      4'h8: t = i_nan;
      4'h9: t = i_nan | i_z;
      4'ha: t = i_nan | ~(i_n | i_z);
      4'hb: t = i_nan | i_z | ~i_n;
      4'hc: t = i_nan | (i_n & ~i_z);
      4'hd: t = i_nan | i_z | i_n;
      4'he: t = ~i_z;
      4'hf: t = 1'b1;
    endcase
    // The upper sixteen tests are not unordered-aware and trap on NaN.
    o_true = ~i_pred[5] & t;
    o_unord = ~i_pred[5] & i_pred[4] & i_nan;
  end
endmodule
`default_nettype wire

// file: rtl/fcbd_top.sv
// APB-mapped floating-point compare and conditional branch decoder.
`timescale 1ns/1ns
`default_nettype none
module fcbd_top
  import fcbd_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_br_unord_req,
  output logic             o_branch_true
);

  // ==========================================================================
  // State
  fcbd_state_s q;
  fcbd_state_s d;
  fcbd_dec_s   dec;
  logic [15:0] w1;
  logic [15:0] w2;
  logic        top_ok;
  logic        fmt_small;
  logic        ea_legal;
  logic        cmp_n;
  logic        cmp_z;
  logic        cmp_nan;
  logic        p_true;
  logic        p_unord;
  logic        acc;
  logic        wr;
  logic        rd_ok;
  logic [31:0] rd_data;

  assign o_prdata      = q.prdata;
  assign o_pready      = q.pready;
  assign o_pslverr     = q.pslverr;
  assign o_br_unord_req = q.fpsr[EX_BR_UNORD];
  assign o_branch_true = q.br_true;

  // ==========================================================================
  // Instruction field decode
  always_comb begin
    w1 = q.instr[31:16];
    w2 = q.instr[15:0];
    top_ok = (w1[15:12] == TOP_NIB);
    dec.id_ok = (w1[11:9] == q.id);
    dec.is_cmp = top_ok && (w1[8:6] == CMP_SEL) && (w2[6:0] == CMP_EXT)
                 && !w2[15] && !w2[13];
    dec.is_br = top_ok && (w1[8:7] == BR_SEL);
    dec.rm = w2[14];
    dec.spec = w2[12:10];
    dec.dst = w2[9:7];
    dec.size = w1[6];
    dec.pred = w1[5:0];
    fmt_small = (dec.spec == FMT_L) || (dec.spec == FMT_S)
                || (dec.spec == FMT_W) || (dec.spec == FMT_B);
    unique case (w1[5:3])
      EA_DREG: ea_legal = fmt_small;
      EA_AREG: ea_legal = 1'b0;
      EA_EXT: ea_legal = (w1[2:0] == EX_ABSW) || (w1[2:0] == EX_ABSL)
                         || (w1[2:0] == EX_IMM) || (w1[2:0] == EX_PCD)
                         || (w1[2:0] == EX_PCX);
      default: ea_legal = 1'b1;
    endcase
    // Register mode ignores the address field, which the host zeroes.
    dec.ea_ok = !dec.rm || ((dec.spec != FMT_BAD) && ea_legal);
  end

  // ==========================================================================
  // Condition code table and predicate test
  fcbd_cmp_cc u_cc (
    .i_opnd (q.opnd),
    .o_n    (cmp_n),
    .o_z    (cmp_z),
    .o_nan  (cmp_nan)
  );

  fcbd_cond_eval u_cond (
    .i_pred (dec.pred),
    .i_n    (q.fpsr[CC_N]),
    .i_z    (q.fpsr[CC_Z]),
    .i_nan  (q.fpsr[CC_NAN]),
    .o_true (p_true),
    .o_unord (p_unord)
  );

  // ==========================================================================
  // Register read mux
  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (i_paddr)
      A_CTRL:  rd_data = {28'h0000000, q.st[1], q.id};
      A_INSTR: rd_data = q.instr;
      A_OPND:  rd_data = {21'h000000, q.opnd};
      A_FPSR:  rd_data = q.fpsr;
      A_DISP:  rd_data = q.disp;
      A_DEC:   rd_data = {14'h0000, q.dec};
      A_BRCH:  rd_data = {31'h00000000, q.br_true};
      default: rd_ok = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    acc = i_psel && i_penable;
    // A write lands on the edge where the master sees pready high.
    wr = acc && q.pready && i_pwrite && rd_ok;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    if (acc && !q.pready) begin
      d.pready = 1'b1;
      d.pslverr = !rd_ok;
      d.prdata = (rd_ok && !i_pwrite) ? rd_data : 32'h0000_0000;
    end
    if (wr) begin
      unique case (i_paddr)
        A_CTRL: d.id = i_pwdata[2:0];
        A_INSTR: begin
          d.instr = i_pwdata;
          d.st = ST_EXEC;
        end
        A_OPND: d.opnd = fcbd_opnd_s'(i_pwdata[10:0]);
        A_FPSR: d.fpsr = i_pwdata;
        A_DISP: d.disp = i_pwdata;
        default: d.dec = q.dec;
      endcase
    end
    unique case (q.st)
      ST_IDLE: d.st = d.st;
      ST_EXEC: begin
        d.st = ST_IDLE;
        d.dec = dec;
        if (dec.is_cmp && dec.id_ok && dec.ea_ok) begin
          d.fpsr[CC_N] = cmp_n;
          d.fpsr[CC_Z] = cmp_z;
          d.fpsr[CC_NAN] = cmp_nan;
          d.fpsr[CC_I] = 1'b0;
          d.fpsr[EX_BR_UNORD] = 1'b0;
          d.fpsr[EX_SIG_NAN] = q.opnd.dst_sig_nan | q.opnd.src_sig_nan;
          d.fpsr[EX_OPND_ERR] = 1'b0;
          d.fpsr[EX_OVER] = 1'b0;
          d.fpsr[EX_UNDER] = 1'b0;
          d.fpsr[EX_DIV_ZERO] = 1'b0;
          d.fpsr[EX_INEXACT] = 1'b0;
          d.fpsr[EX_DEC_INEXACT] = dec.rm && (dec.spec == FMT_P)
                                   && q.opnd.dec_inexact_in;
        end
        if (dec.is_br && dec.id_ok) begin
          d.br_true = p_true;
          if (p_unord) begin
            d.fpsr[EX_BR_UNORD] = 1'b1;
          end
          if (dec.size) begin
            d.disp_out = q.disp;
          end else begin
            d.disp_out = {{16{q.disp[31]}}, q.disp[31:16]};
          end
        end
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '{st: ST_IDLE, id: RST_ID, fpsr: RST_FPSR, default: '0};
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence exec_s;
    q.st == ST_EXEC;
  endsequence

  sequence exec_cmp_s;
    exec_s and (dec.is_cmp && dec.id_ok && dec.ea_ok);
  endsequence

  sequence exec_br_s;
    exec_s and (dec.is_br && dec.id_ok);
  endsequence

  disp_short_a: assert property (
    exec_br_s and !dec.size |=>
      q.disp_out == {{16{$past(q.disp[31])}}, $past(q.disp[31:16])})
    else $error("short displacement not sign extended");

  disp_long_a: assert property (
    exec_br_s and dec.size |=> q.disp_out == $past(q.disp))
    else $error("long displacement not taken whole");

  pred_equal_a: assert property (
    exec_br_s and (dec.pred == 6'h01) |=>
      q.br_true == $past(q.fpsr[CC_Z]))
    else $error("equal test does not follow zero code");

  id_filter_a: assert property (
    exec_s and !dec.id_ok |=> $stable(q.fpsr))
    else $error("foreign coprocessor instruction changed status");

  inf_clear_a: assert property (
    exec_cmp_s |=> !q.fpsr[CC_I])
    else $error("compare left infinity code set");

  quot_keep_a: assert property (
    exec_cmp_s |=> q.fpsr[23:16] == $past(q.fpsr[23:16]))
    else $error("compare altered quotient byte");

  exc_clear_a: assert property (
    exec_cmp_s |=> q.fpsr[EX_OPND_ERR:EX_INEXACT] == 5'h00 && !q.fpsr[EX_BR_UNORD])
    else $error("compare left exception bits set");

  dec_inexact_a: assert property (
    exec_cmp_s |=> q.fpsr[EX_DEC_INEXACT] ==
      (q.dec.rm && (q.dec.spec == FMT_P) && q.opnd.dec_inexact_in))
    else $error("decimal input inexact bit wrong");

  // ==========================================================================
  // Condition code table checks
  // These restate the table by operand class, so a wrong branch in the
  // lookup shows up even when the random operands rarely reach it.
  fin_same_a: assert property (
    exec_cmp_s and (q.opnd.dst_cls == CL_FIN) && (q.opnd.src_cls == CL_FIN)
      && (q.opnd.dst_sign == q.opnd.src_sign) |=>
      q.fpsr[CC_N] == $past(q.opnd.diff_n) && q.fpsr[CC_Z] == $past(q.opnd.diff_z))
    else $error("same sign compare does not follow difference");

  fin_mixed_a: assert property (
    exec_cmp_s and (q.opnd.dst_cls == CL_FIN) && (q.opnd.src_cls == CL_FIN)
      && (q.opnd.dst_sign != q.opnd.src_sign) |=>
      q.fpsr[CC_N] == $past(q.opnd.dst_sign) && !q.fpsr[CC_Z])
    else $error("mixed sign compare codes wrong");

  zero_zero_a: assert property (
    exec_cmp_s and (q.opnd.dst_cls == CL_ZERO) && (q.opnd.src_cls == CL_ZERO) |=>
      q.fpsr[CC_Z] && q.fpsr[CC_N] == $past(q.opnd.dst_sign))
    else $error("zero against zero codes wrong");

  zero_fin_a: assert property (
    exec_cmp_s and (q.opnd.dst_cls == CL_ZERO) && (q.opnd.src_cls == CL_FIN) |=>
      q.fpsr[CC_N] == !$past(q.opnd.src_sign) && !q.fpsr[CC_Z])
    else $error("zero against finite codes wrong");

  pos_inf_src_a: assert property (
    exec_cmp_s and (q.opnd.src_cls == CL_INF) && !q.opnd.src_sign
      && ((q.opnd.dst_cls == CL_FIN) || (q.opnd.dst_cls == CL_ZERO)) |=>
      q.fpsr[CC_N] && !q.fpsr[CC_Z])
    else $error("positive infinite source codes wrong");

  inf_dst_a: assert property (
    exec_cmp_s and (q.opnd.dst_cls == CL_INF)
      && ((q.opnd.src_cls == CL_FIN) || (q.opnd.src_cls == CL_ZERO)) |=>
      q.fpsr[CC_N] == $past(q.opnd.dst_sign) && !q.fpsr[CC_Z])
    else $error("infinite destination codes wrong");

  diff_kept_a: assert property (
    exec_cmp_s |=> q.instr == $past(q.instr) && q.opnd == $past(q.opnd))
    else $error("compare wrote a register");

  // ==========================================================================
  // Field decode checks
  reg_mode_a: assert property (
    exec_s and !dec.rm |=> q.dec.ea_ok)
    else $error("register mode rejected by address field");

  areg_reject_a: assert property (
    exec_s and dec.rm && (w1[5:3] == EA_AREG) |=> !q.dec.ea_ok)
    else $error("address register direct accepted");

  spec_field_a: assert property (
    exec_s |=> q.dec.spec == q.instr[12:10])
    else $error("source specifier not taken from second word");

  dst_field_a: assert property (
    exec_s |=> q.dec.dst == q.instr[9:7])
    else $error("destination field not taken from second word");

  cmp_match_a: assert property (
    exec_s and (q.instr[31:28] == TOP_NIB) && (q.instr[24:22] == CMP_SEL)
      && (q.instr[6:0] == CMP_EXT) && !q.instr[15] && !q.instr[13] |=>
      q.dec.is_cmp)
    else $error("compare opcode not recognised");

  unord_set_a: assert property (
    exec_br_s and (dec.pred[5:4] == 2'b01) && q.fpsr[CC_NAN] |=>
      q.fpsr[EX_BR_UNORD])
    else $error("unordered branch flag not raised");

  dreg_fmt_a: assert property (
    exec_s and dec.rm && (w1[5:3] == EA_DREG) && !fmt_small |=>
      !q.dec.ea_ok)
    else $error("data register direct accepted for wide format");

  inf_inf_a: assert property (
    exec_cmp_s and (q.opnd.dst_cls == CL_INF) && (q.opnd.src_cls == CL_INF)
      && q.opnd.dst_sign && q.opnd.src_sign |=>
      q.fpsr[CC_N] && q.fpsr[CC_Z])
    else $error("negative infinities did not set both codes");

  apb_answer_a: assert property (
    i_psel && i_penable && !q.pready |=> q.pready ##1 !q.pready)
    else $error("apb answer not a single cycle pulse");

endmodule
`default_nettype wire

// file: verification/fcbd_host.sv
// Host processor model that issues APB transfers to the decoder.
`timescale 1ns/1ns
`default_nettype none
module fcbd_host (
  input  wire logic        i_clk,
  input  wire logic        i_pready,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata
);
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 8'h00;
    o_pwdata  = 32'h0000_0000;
  end

  // ==========================================================================
  // One transfer; the request is held until pready is seen high, so a slow
  // slave only costs time and the bench watchdog ends a hang.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= w;
    o_paddr   <= a;
    o_pwdata  <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verification/test_fcbd_top.sv
// Self-checking bench for the compare and branch decoder.
`timescale 1ns/1ns
`default_nettype none
module test_fcbd_top;
  import fcbd_pkg::*;
  typedef struct packed {logic err; logic [31:0] msk; logic [31:0] val;} fcbd_note_s;
  logic        clk, nrst, psel, pen, pwr, pready, pslverr, unord, brt;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, fp, e;
  logic [2:0]  id, md, rg, sp, ds;
  logic        rm, okea, n, z, nan, t, b;
  fcbd_note_s  notes[$];
  fcbd_note_s  nt;
  int          n_mismatch, checks_done, seed = 88;

  fcbd_host host (.i_clk(clk), .i_pready(pready), .o_psel(psel), .o_penable(pen),
                  .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata));
  fcbd_top uut (.i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
                .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
                .o_pready(pready), .o_pslverr(pslverr), .o_br_unord_req(unord), .o_branch_true(brt));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================================
  // Reporting
  task automatic fail(input string m);
    n_mismatch++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic close_out;
    if (notes.size() != 0) n_mismatch++;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Every answer is matched against the oldest note.
  always @(posedge clk) begin
    if (nrst && pready === 1'b1) begin
      checks_done++;
      if (notes.size() == 0) begin
        fail("answer without request");
      end else begin
        nt = notes.pop_front();
        if ({pslverr, prdata & nt.msk} !== {nt.err, nt.val}) fail("bus answer differs");
      end
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    notes.push_back('{1'b0, 32'hffff_ffff, 32'h0});
    host.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
                    input logic er = 1'b0);
    notes.push_back('{er, m, v & m});
    host.xfer(1'b0, a, 32'h0);
  endtask

  // ==========================================================================
  // Reference models
  // compare table.
  function automatic logic [1:0] exp_cc(input logic [10:0] o);
    if (o[1:0] == CL_INF) return {o[2], o[5:4] == CL_INF && o[6] == o[2]};
    if (o[5:4] == CL_INF) return {!o[6], 1'b0};
    if (o[1:0] == CL_FIN && o[5:4] == CL_FIN && o[2] == o[6]) return {o[8], o[9]};
    if (o[1:0] == CL_ZERO && o[5:4] == CL_ZERO) return {o[2], 1'b1};
    if (o[1:0] == CL_ZERO) return {!o[6], 1'b0};
    return {o[2], 1'b0};
  endfunction

  function automatic logic cond(input logic [3:0] c, input logic n, input logic z,
                                input logic u);
    logic [15:0] v;
    v = {1'b1, !z, u|z|n, u|(n&!z), u|z|!n, u|!(z|n), u|z, u, !u, !(u|z),
         z|(n&!u), n&!(u|z), z|!(u|n), !(u|z|n), z, 1'b0};
    return v[c];
  endfunction

  initial begin
    #(8*40000);
    fail("watchdog expired");
    close_out();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(A_CTRL, 32'hf, {29'h0, RST_ID});
    rd(A_FPSR, 32'hffff_ffff, RST_FPSR);
    rd(8'h1c, 32'hffff_ffff, 32'h0, 1'b1);
    for (int i = 0; i < 120; i++) begin
      r = $random(seed);
      id = r[16] & r[17] ? 3'h2 : RST_ID;
      rm = r[11];
      md = r[14:12];
      rg = r[20:18];
      sp = (rm && r[23:21] == FMT_BAD) ? FMT_P : r[23:21];
      ds = r[26:24];
      if (!rm) {md, rg} = 6'h0;
      okea = !rm || (md >= 3'h2 && md <= 3'h6) || (md == EA_EXT && rg <= EX_IMM)
             || (md == EA_DREG && sp inside {FMT_L, FMT_S, FMT_W, FMT_B});
      {n, z} = exp_cc(r[10:0]);
      nan = r[1:0] == CL_NAN || r[5:4] == CL_NAN;
      fp = 32'h0fab_ff00;
      e = (id == RST_ID && okea) ? {4'h0, n & !nan, z & !nan, 1'b0, nan, 8'hab, 1'b0,
          r[3] | r[7], 5'h0, rm && sp == FMT_P && r[10], 8'h00} : fp;
      wr(A_OPND, {21'h0, r[10:0]});
      wr(A_FPSR, fp);
      wr(A_INSTR, {TOP_NIB, id, CMP_SEL, md, rg, 1'b0, rm, 1'b0, sp, ds, CMP_EXT});
      rd(A_FPSR, 32'hffff_ffff, e);
      rd(A_OPND, 32'h7ff, {21'h0, r[10:0]});
      rd(A_DEC, 32'h3efc0, {14'h0, 2'b10, id == RST_ID, rm, okea, 1'b0, sp, ds, 6'h0});
    end
    for (int p = 0; p < 64; p++) begin
      r = $random(seed);
      t = p[5] ? 1'b0 : cond(p[3:0], r[2], r[1], r[0]);
      b = !p[5] && p[4] && r[0];
      fp = {4'h0, r[2], r[1], 1'b0, r[0], 24'h0};
      wr(A_FPSR, fp);
      wr(A_DISP, r);
      wr(A_INSTR, {TOP_NIB, RST_ID, BR_SEL, r[3], p[5:0], 16'h0});
      rd(A_BRCH, 32'h1, {31'h0, t});
      rd(A_FPSR, 32'hffff_ffff, fp | {16'h0, b, 15'h0});
      checks_done++;
      if ({brt, unord} !== {t, b}) fail("branch outputs differ");
    end
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule
`default_nettype wire
